// ---- inc/gp3_pkg.sv ----
/*
 * gp3_pkg: register map, reset values and field positions of the
 * eight-bit general-purpose port three.
 * Assumes an APB slave with 32-bit data and word-aligned registers.
 */
package gp3_pkg;

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    // register indices; the byte address is four times the index
    localparam logic [31:0] GP3_IDX_OUTPUT_LATCH = 32'hFFFFF006;
    localparam logic [31:0] GP3_IDX_DIRECTION = 32'hFFFFF026;
    localparam logic [31:0] GP3_IDX_PULLUP = 32'hFFFFF046;
    localparam logic [31:0] GP3_IDX_ADDR_MODE = 32'hFFFFF066;
    localparam logic [31:0] GP3_IDX_FILTERED = 32'hFFFFF086;
    // top two index bits fall off a 32-bit byte address
    localparam logic [31:0] GP3_ADDR_OUTPUT_LATCH =
        {GP3_IDX_OUTPUT_LATCH[29:0], 2'h0};
    localparam logic [31:0] GP3_ADDR_DIRECTION =
        {GP3_IDX_DIRECTION[29:0], 2'h0};
    localparam logic [31:0] GP3_ADDR_PULLUP =
        {GP3_IDX_PULLUP[29:0], 2'h0};
    localparam logic [31:0] GP3_ADDR_ADDR_MODE =
        {GP3_IDX_ADDR_MODE[29:0], 2'h0};
    localparam logic [31:0] GP3_ADDR_FILTERED =
        {GP3_IDX_FILTERED[29:0], 2'h0};

    // ------------------------------------------------------------
    // reset values and fields
    // ------------------------------------------------------------
    localparam logic [7:0] GP3_RST_OUTPUT_LATCH = 8'h00;
    localparam logic [7:0] GP3_RST_DIRECTION = 8'hFF;
    localparam logic [7:0] GP3_RST_PULLUP = 8'h00;
    localparam logic [2:0] GP3_RST_ADDR_MODE = 3'h0;
    localparam logic [7:0] GP3_ADDR_PIN_MASK = 8'h70;
    localparam int GP3_ADDR_PIN_LO = 4;
    localparam int GP3_TIMER_PIN_LO = 6;
    localparam int GP3_FILTER_DEPTH = 3;

    // register select code
    typedef enum logic [2:0] {
        GP3_SEL_NONE,
        GP3_SEL_LATCH,
        GP3_SEL_DIR,
        GP3_SEL_PULLUP,
        GP3_SEL_MODE,
        GP3_SEL_FILT
    } gp3_sel_t;

endpackage : gp3_pkg

// ---- inc/gp3_filt_if.sv ----
/*
 * gp3_filt_if: carries the two raw timer pin levels to the noise
 * eliminator and the cleaned levels back.
 * Assumes both ends run on one clock.
 */
interface gp3_filt_if;
    logic [1:0] raw;
    logic [1:0] clean;

    modport port (output raw, input clean);
    modport filter (input raw, output clean);
endinterface : gp3_filt_if

// ---- rtl/gp3_noise_filter.sv ----
/*
 * gp3_noise_filter: digital noise eliminator, one channel for each of the two timer pins.
 * An output changes only after the input has held a new level for
 * DEPTH consecutive clocks. Assumes inputs synchronous to sys_clk.
 */
module gp3_noise_filter
    import gp3_pkg::*;
#(
    parameter int DEPTH = GP3_FILTER_DEPTH
) (
    input wire logic sys_clk,
    input wire logic rst,
    gp3_filt_if.filter filt
);

    initial begin
        if (DEPTH < 2 || DEPTH > 16) begin
            $error("gp3_noise_filter: DEPTH out of range");
        end
    end

    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_ch
            logic [DEPTH-1:0] hist;
            logic level;
            wire all_hi = &hist;
            wire all_lo = ~|hist;

            // shift history; level follows only a steady run
            always_ff @(posedge sys_clk or posedge rst) begin
                if (rst) begin
                    hist <= '0;
                    level <= 1'b0;
                end else begin
                    hist <= {hist[DEPTH-2:0], filt.raw[g]};
                    if (all_hi) begin
                        level <= 1'b1;
                    end else if (all_lo) begin
                        level <= 1'b0;
                    end
                end
            end
            assign filt.clean[g] = level;
        end
    endgenerate

endmodule : gp3_noise_filter

// ---- rtl/gp3_port.sv ----
/*
 * gp3_port: eight-bit general-purpose port three with APB registers,
 * per-bit direction, pull-up select, alternate output merge, address
 * output mode and filtered timer inputs.
 * Assumes pin inputs synchronous to sys_clk; the pad wire is resolved
 * outside from pin_out and pin_oe.
 */
// The APB register port was left to the implementer.
module gp3_port
    import gp3_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [7:0] pin_in,
    output logic [7:0] pin_out,
    output logic [7:0] pin_oe,
    output logic [7:0] pin_pullup,
    input wire logic [7:0] alt_out,
    input wire logic [2:0] ext_addr_in,
    output logic [1:0] timer_in
);

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic [7:0] port_three_output_latch;
    logic [7:0] port_three_direction;
    logic [7:0] port_three_pullup_select;
    logic [2:0] address_output_mode_select;

    // ------------------------------------------------------------
    // elaboration checks
    // ------------------------------------------------------------
    // the address and timer pins must sit inside the byte, and no two
    // registers may share a word once the index is scaled to bytes
    localparam logic [31:0] REG_ADDRS [5] = '{GP3_ADDR_OUTPUT_LATCH,
        GP3_ADDR_DIRECTION, GP3_ADDR_PULLUP, GP3_ADDR_ADDR_MODE,
        GP3_ADDR_FILTERED};
    initial begin
        if (GP3_ADDR_PIN_LO + 3 > 8) begin
            $error("gp3_port: address pins fall outside the port");
        end
        if (GP3_TIMER_PIN_LO + 2 > 8) begin
            $error("gp3_port: timer pins fall outside the port");
        end
        for (int i = 0; i < 5; i++) begin
            for (int j = i + 1; j < 5; j++) begin
                if (REG_ADDRS[i] == REG_ADDRS[j]) begin
                    $error("gp3_port: two registers share a word");
                end
            end
        end
    end

    // ------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------
    function automatic gp3_sel_t decode(input logic [31:0] a);
        gp3_sel_t s;
        s = GP3_SEL_NONE;
        if (a == GP3_ADDR_OUTPUT_LATCH) s = GP3_SEL_LATCH;
        if (a == GP3_ADDR_DIRECTION) s = GP3_SEL_DIR;
        if (a == GP3_ADDR_PULLUP) s = GP3_SEL_PULLUP;
        if (a == GP3_ADDR_ADDR_MODE) s = GP3_SEL_MODE;
        if (a == GP3_ADDR_FILTERED) s = GP3_SEL_FILT;
        return s;
    endfunction : decode

    // byte enable: a bus without pstrb use writes all, low lane governs
    wire gp3_sel_t sel = decode(paddr);
    wire access_en = psel && penable;
    wire wr_en = access_en && pwrite && pstrb[0];
    wire wr_latch = wr_en && (sel == GP3_SEL_LATCH);
    wire wr_dir = wr_en && (sel == GP3_SEL_DIR);
    wire wr_pullup = wr_en && (sel == GP3_SEL_PULLUP);
    wire wr_mode = wr_en && (sel == GP3_SEL_MODE);
    wire unmapped = (sel == GP3_SEL_NONE);

    // ------------------------------------------------------------
    // pin datapath
    // ------------------------------------------------------------
    // address bits ride on pins four to six when the mode bit is set
    logic [7:0] addr_drive;
    logic [7:0] addr_en;
    always_comb begin
        addr_drive = '0;
        addr_en = '0;
        for (int i = 0; i < 3; i++) begin
            addr_en[GP3_ADDR_PIN_LO + i] = address_output_mode_select[i];
            addr_drive[GP3_ADDR_PIN_LO + i] =
                address_output_mode_select[i] & ext_addr_in[i];
        end
    end

    // ------------------------------------------------------------
    // per-pin cell
    // ------------------------------------------------------------
    // eight identical cells; a generate keeps a fix from missing a bit
    logic [7:0] is_output;
    logic [7:0] next_pin_out;
    logic [7:0] next_pin_oe;
    logic [7:0] next_pin_pullup;
    logic [7:0] read_port;
    genvar b;
    generate
        for (b = 0; b < 8; b++) begin : g_pin
            // direction bit low makes the pin an output
            assign is_output[b] = ~port_three_direction[b];
            // latch OR alternate OR address function
            assign next_pin_out[b] = port_three_output_latch[b]
                | alt_out[b] | addr_drive[b];
            // address pins need the direction cleared; software's duty
            assign next_pin_oe[b] = is_output[b];
            // pull-up only useful while the pin is an input
            assign next_pin_pullup[b] = port_three_pullup_select[b]
                & port_three_direction[b];
            // input bits show the pad, output bits the latch
            assign read_port[b] = is_output[b]
                ? port_three_output_latch[b] : pin_in[b];
        end
    endgenerate

    // ------------------------------------------------------------
    // noise eliminator for the timer inputs
    // ------------------------------------------------------------
    gp3_filt_if filt_bus ();
    assign filt_bus.raw = pin_in[GP3_TIMER_PIN_LO +: 2];

    gp3_noise_filter #(
        .DEPTH(GP3_FILTER_DEPTH)
    ) u_filter (
        .sys_clk(sys_clk),
        .rst(rst),
        .filt(filt_bus.filter)
    );

    // read data selection
    logic [31:0] next_prdata;
    always_comb begin
        next_prdata = '0;
        unique case (sel)
            GP3_SEL_LATCH: next_prdata = {24'h000000, read_port};
            GP3_SEL_DIR: next_prdata = {24'h000000, port_three_direction};
            GP3_SEL_PULLUP: begin
                next_prdata = {24'h000000, port_three_pullup_select};
            end
            GP3_SEL_MODE: begin
                next_prdata = {29'h0, address_output_mode_select};
            end
            GP3_SEL_FILT: next_prdata = {30'h0, filt_bus.clean};
            GP3_SEL_NONE: next_prdata = '0;
        endcase
    end

    // ------------------------------------------------------------
    // register writes
    // ------------------------------------------------------------
    // the latch takes every write, whatever the pin direction
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            port_three_output_latch <= GP3_RST_OUTPUT_LATCH;
        end else if (wr_latch) begin
            port_three_output_latch <= pwdata[7:0];
        end
    end

    // direction: full byte write; bit set/clear is read-modify-write
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            port_three_direction <= GP3_RST_DIRECTION;
        end else if (wr_dir) begin
            port_three_direction <= pwdata[7:0];
        end
    end

    // pull-up select, one bit per pin
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            port_three_pullup_select <= GP3_RST_PULLUP;
        end else if (wr_pullup) begin
            port_three_pullup_select <= pwdata[7:0];
        end
    end

    // address output mode for pins four to six
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            address_output_mode_select <= GP3_RST_ADDR_MODE;
        end else if (wr_mode) begin
            address_output_mode_select <= pwdata[2:0];
        end
    end

    // ------------------------------------------------------------
    // registered outputs
    // ------------------------------------------------------------
    // one-cycle lag on pins keeps every output straight from a flop
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            pin_out <= GP3_RST_OUTPUT_LATCH;
            pin_oe <= ~GP3_RST_DIRECTION;
            pin_pullup <= GP3_RST_PULLUP;
            timer_in <= 2'h0;
        end else begin
            pin_out <= next_pin_out;
            pin_oe <= next_pin_oe;
            pin_pullup <= next_pin_pullup;
            timer_in <= filt_bus.clean;
        end
    end

    // APB: zero wait states, read data captured in setup phase
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            prdata <= '0;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            prdata <= (psel && !penable && !pwrite) ? next_prdata : prdata;
            pready <= psel && !penable;
            pslverr <= psel && !penable && unmapped;
        end
    end

endmodule : gp3_port

// ---- sim/gp3_assertions.sv ----
/* gp3_assertions: port-level checks for gp3_port.
   Assumes it is bound to gp3_port and sees only its ports. */
module gp3_assertions
    import gp3_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [7:0] pin_in,
    input wire logic [7:0] pin_out,
    input wire logic [7:0] pin_oe,
    input wire logic [7:0] pin_pullup,
    input wire logic [7:0] alt_out,
    input wire logic [1:0] timer_in
);
    // ------------------------------------------------------------
    // bus and pad relations
    // ------------------------------------------------------------
    wire logic mapped = paddr inside {GP3_ADDR_OUTPUT_LATCH,
        GP3_ADDR_DIRECTION, GP3_ADDR_PULLUP, GP3_ADDR_ADDR_MODE,
        GP3_ADDR_FILTERED};
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    sequence s_setup; psel && !penable; endsequence
    sequence s_wr(logic [31:0] a);
        psel && penable && pwrite && pstrb[0] && paddr == a;
    endsequence
    property p_ans; s_setup |=> pready ##1 !pready; endproperty
    a_ans: assert property (p_ans) else $error("late answer");
    property p_err; s_setup ##0 !mapped |=> pslverr; endproperty
    a_err: assert property (p_err) else $error("no error");
    property p_dir;
        s_wr(GP3_ADDR_DIRECTION) |-> ##2 pin_oe == ~$past(pwdata[7:0], 2);
    endproperty
    a_dir: assert property (p_dir) else $error("bad enable");
    // latch reaches the pad two edges after the access phase
    property p_lat; s_wr(GP3_ADDR_OUTPUT_LATCH) |-> ##2
        pin_out[3:0] == ($past(pwdata[3:0], 2) | $past(alt_out[3:0]));
    endproperty
    a_lat: assert property (p_lat) else $error("bad drive");
    property p_pul; s_wr(GP3_ADDR_PULLUP) |-> ##2
        pin_pullup == ($past(pwdata[7:0], 2) & ~pin_oe);
    endproperty
    a_pul: assert property (p_pul) else $error("bad pull");
    property p_alt; 1 |=> (pin_out & $past(alt_out)) == $past(alt_out);
    endproperty
    a_alt: assert property (p_alt) else $error("alt lost");
    property p_flt;
        $stable(pin_in[7:6])[*8] |-> timer_in == pin_in[7:6];
    endproperty
    a_flt: assert property (p_flt) else $error("filter stuck");
    property p_rst; $fell(rst) |-> pin_oe == 8'h00 && pin_pullup == 8'h00;
    endproperty
    a_rst: assert property (p_rst) else $error("not input");
endmodule : gp3_assertions

bind gp3_port gp3_assertions u_chk (.*);

// ---- sim/gp3_board.sv ----
/* gp3_board: board side of the eight pads of port three.
   Assumes the bench chooses which pads an outside source drives. */
module gp3_board (
    input wire logic sys_clk,
    input wire logic [7:0] pin_out,
    input wire logic [7:0] pin_oe,
    input wire logic [7:0] pin_pullup,
    input wire logic [7:0] ext_val,
    input wire logic [7:0] ext_en,
    output logic [7:0] pin_in
);
    timeunit 1ns;
    timeprecision 1ps;
    // loose pads wander so a missing pull-up cannot pass as a held level
    logic [7:0] wander = 8'h55;
    always @(posedge sys_clk) wander <= ~wander;
    // device drive wins, then the outside source, then the pull-up
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val)
        | (~pin_oe & ~ext_en & (pin_pullup | wander));
endmodule : gp3_board

// ---- sim/tb_eight_bit_gpio_port_three.sv ----
/* tb_eight_bit_gpio_port_three: register tests of port three.
   Assumes gp3_port, the gp3_board pad model and the bound checker. */
module tb_eight_bit_gpio_port_three
    import gp3_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk, rst = 1'h1, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
    logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, rd;
    logic [3:0] pstrb = 4'hF;
    logic [7:0] alt_out = 8'h00, ext_val = 8'h5A, ext_en = 8'hFF;
    logic [7:0] pin_in, pin_out, pin_oe, pin_pullup;
    logic [2:0] ext_addr_in = 3'h0;
    logic [1:0] timer_in;
    logic pready, pslverr, err;
    int n_mismatch = 0;
    int n_tests = 0;
    gp3_port u_dut (.*);
    gp3_board u_board (.*);
    initial begin
        sys_clk = 1'h0;
        forever #4 sys_clk = ~sys_clk;
    end
    // ------------------------------------------------------------
    // bus and compare tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // request held until pready is seen high at a rising edge
    task automatic apb(input logic w, input logic [31:0] a,
            input logic [7:0] d);
        int k = 0;
        @(posedge sys_clk);
        psel <= 1'h1;
        penable <= 1'h0;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge sys_clk);
        penable <= 1'h1;
        do begin
            @(posedge sys_clk);
            k++;
        end while (pready !== 1'h1 && k < 20);
        if (pready !== 1'h1) n_mismatch++;
        rd = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask : apb
    task automatic rchk(input logic [31:0] a, input logic [7:0] e);
        apb(1'h0, a, 8'h00);
        chk(rd, {24'h0, e});
    endtask : rchk
    task automatic idle(input int n);
        repeat (n) @(negedge sys_clk);
    endtask : idle
    task automatic drv(input logic [7:0] v, input int n);
        @(posedge sys_clk);
        ext_val <= v;
        idle(n);
    endtask : drv
    task automatic wrap_up;
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : wrap_up
    initial begin
        repeat (5) @(posedge sys_clk);
        rst <= 1'h0;
        rchk(GP3_ADDR_DIRECTION, 8'hFF);
        rchk(GP3_ADDR_PULLUP, 8'h00);
        rchk(GP3_ADDR_OUTPUT_LATCH, 8'h5A);
        apb(1'h1, GP3_ADDR_OUTPUT_LATCH, 8'hC3);
        rchk(GP3_ADDR_OUTPUT_LATCH, 8'h5A);
        apb(1'h1, GP3_ADDR_DIRECTION, 8'hF0);
        idle(3);
        chk(pin_oe, 8'h0F);
        chk(pin_out, 8'hC3);
        rchk(GP3_ADDR_OUTPUT_LATCH, 8'h53);
        apb(1'h0, GP3_ADDR_DIRECTION, 8'h00);
        apb(1'h1, GP3_ADDR_DIRECTION, rd[7:0] & 8'h7F);
        rchk(GP3_ADDR_DIRECTION, 8'h70);
        apb(1'h1, GP3_ADDR_DIRECTION, 8'hF0);
        apb(1'h1, GP3_ADDR_PULLUP, 8'hFF);
        @(posedge sys_clk);
        ext_en <= 8'h0F;
        idle(3);
        chk(pin_pullup, 8'hF0);
        rchk(GP3_ADDR_OUTPUT_LATCH, 8'hF3);
        @(posedge sys_clk);
        ext_en <= 8'hFF;
        // a one-cycle spike must not reach the timer
        drv(8'h40, 12);
        chk(timer_in, 2'h1);
        drv(8'h80, 1);
        drv(8'h40, 12);
        chk(timer_in, 2'h1);
        drv(8'h80, 12);
        chk(timer_in, 2'h2);
        rchk(GP3_ADDR_FILTERED, 8'h02);
        apb(1'h1, GP3_ADDR_OUTPUT_LATCH, 8'h00);
        @(posedge sys_clk);
        alt_out <= 8'h0C;
        ext_addr_in <= 3'h5;
        idle(3);
        chk(pin_out, 8'h0C);
        apb(1'h1, GP3_ADDR_ADDR_MODE, 8'h07);
        apb(1'h1, GP3_ADDR_DIRECTION, 8'h8F);
        idle(3);
        chk(pin_out, 8'h5C);
        apb(1'h0, 32'hFFFFF0A6, 8'h00);
        chk({rd[30:0], err}, 32'h1);
        @(posedge sys_clk);
        rst <= 1'h1;
        idle(2);
        chk(pin_oe, 8'h00);
        @(posedge sys_clk);
        rst <= 1'h0;
        rchk(GP3_ADDR_DIRECTION, 8'hFF);
        wrap_up;
    end
    // the tests need some 120 cycles; stop far beyond that
    initial begin
        #40000;
        n_mismatch++;
        wrap_up;
    end
endmodule : tb_eight_bit_gpio_port_three
